// File: design/cbl_device.sv
// loading port of the programmable array: peripheral writes and byte memory fetch
// assumes pins arrive from outside the clock domain; serial stream leaves on user side
`timescale 1ns/10ps
module cbl_device #(
    parameter int CONFIG_CLOCK_DIV = cbl_pkg::CONFIG_CLOCK_DIV
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic memory_mode,
    cbl_if.device     link,
    output logic      config_clock,
    output logic      cfg_data,
    output logic      cfg_bit_valid,
    output logic      cfg_active
);
    localparam int BW    = cbl_pkg::BYTE_W;
    localparam int CW    = cbl_pkg::CNT_W;
    localparam int SYN_W = 6 + 2 * BW;
    localparam int DIV_W = $clog2(CONFIG_CLOCK_DIV);

    typedef enum logic [4:0] {
        DV_CLEAR    = 5'h01,
        DV_WAIT     = 5'h02,
        DV_PERIPH   = 5'h04,
        DV_MEM_LOW  = 5'h08,
        DV_MEM_HIGH = 5'h10
    } cbl_dev_state_t;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [SYN_W-1:0] pin_raw;
    logic [SYN_W-1:0] meta_q;
    logic [SYN_W-1:0] sync_q;

    assign pin_raw = {link.cfg_reset_b, link.done_prog_b, link.chip_select_a_b,
                      link.chip_select_b_b, link.chip_select_c_b, link.write_strobe_b,
                      link.wr_data, link.mem_data};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
        end
    end

    logic          reset_ok;
    logic          prog_ok;
    logic          sel_on;
    logic [BW-1:0] wr_data_s;
    logic [BW-1:0] mem_data_s;

    assign reset_ok   = sync_q[SYN_W-1];
    assign prog_ok    = sync_q[SYN_W-2];
    assign sel_on     = sync_q[2*BW+3:2*BW] == 4'h0;
    assign wr_data_s  = sync_q[2*BW-1:BW];
    assign mem_data_s = sync_q[BW-1:0];

    // ****************************************
    // state machine
    // ****************************************
    cbl_dev_state_t state_q;
    cbl_dev_state_t state_d;
    logic [3:0]     clr_cnt_q;
    logic [CW-1:0]  rd_cnt_q;
    logic [CW-1:0]  rd_lim;
    logic           hold_vld_q;

    assign rd_lim = (state_q == DV_MEM_LOW) ? cbl_pkg::READ_LOW_CYC : cbl_pkg::READ_HIGH_CYC;

    always_comb begin
        state_d = state_q;
        case (state_q)
            DV_CLEAR: begin
                if (prog_ok && clr_cnt_q == cbl_pkg::INIT_CLEAR_CYC) begin
                    state_d = DV_WAIT;
                end
            end
            DV_WAIT: begin
                if (!prog_ok) begin
                    state_d = DV_CLEAR;
                end else if (reset_ok) begin
                    state_d = memory_mode ? DV_MEM_LOW : DV_PERIPH;
                end
            end
            DV_PERIPH: begin
                if (!prog_ok || !reset_ok) begin
                    state_d = DV_CLEAR;
                end
            end
            DV_MEM_LOW: begin
                if (!prog_ok || !reset_ok) begin
                    state_d = DV_CLEAR;
                end else if (rd_cnt_q == rd_lim && !hold_vld_q) begin
                    state_d = DV_MEM_HIGH;
                end
            end
            DV_MEM_HIGH: begin
                if (!prog_ok || !reset_ok) begin
                    state_d = DV_CLEAR;
                end else if (rd_cnt_q == rd_lim) begin
                    state_d = DV_MEM_LOW;
                end
            end
            default: begin
                state_d = DV_CLEAR;
            end
        endcase
    end

    logic in_clear;
    logic mem_take;
    logic mem_next;

    assign in_clear = state_q == DV_CLEAR;
    assign mem_take = state_q == DV_MEM_LOW && state_d == DV_MEM_HIGH;
    assign mem_next = state_q == DV_MEM_HIGH && state_d == DV_MEM_LOW;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= DV_CLEAR;
            clr_cnt_q <= 4'h0;
            rd_cnt_q  <= '0;
        end else begin
            state_q   <= state_d;
            clr_cnt_q <= (!in_clear || !prog_ok) ? 4'h0 :
                         clr_cnt_q + 4'((clr_cnt_q != cbl_pkg::INIT_CLEAR_CYC));
            rd_cnt_q  <= (state_d != state_q) ? '0 : rd_cnt_q + CW'((rd_cnt_q != rd_lim));
        end
    end

    // ****************************************
    // config clock generator
    // ****************************************
    logic [DIV_W-1:0] div_q;
    logic             tick;

    assign tick = div_q == DIV_W'(CONFIG_CLOCK_DIV - 1);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q        <= '0;
            config_clock <= 1'h0;
        end else begin
            div_q        <= tick ? '0 : div_q + DIV_W'(1);
            config_clock <= !tick && (div_q >= DIV_W'(CONFIG_CLOCK_DIV / 2 - 1));
        end
    end

    // ****************************************
    // peripheral write capture
    // ****************************************
    logic [3:0]    strobe_cnt_q;
    logic [BW-1:0] data_lat_q;
    logic          wr_end;

    assign wr_end = state_q == DV_PERIPH && !sel_on && strobe_cnt_q == cbl_pkg::WRITE_MIN_CYC;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_cnt_q <= 4'h0;
            data_lat_q   <= '0;
        end else begin
            strobe_cnt_q <= (sel_on && state_q == DV_PERIPH) ?
                            strobe_cnt_q + 4'((strobe_cnt_q != cbl_pkg::WRITE_MIN_CYC)) : 4'h0;
            if (sel_on) begin
                data_lat_q <= wr_data_s;
            end
        end
    end

    // ****************************************
    // two-stage buffer and shifter
    // ****************************************
    logic [BW-1:0] hold_q;
    logic [BW-1:0] sh_q;
    logic [3:0]    sh_cnt_q;
    logic          hold_load;
    logic [BW-1:0] hold_src;
    logic          take_w;

    assign hold_load = wr_end || mem_take;
    assign hold_src  = mem_take ? mem_data_s : data_lat_q;
    assign take_w    = tick && hold_vld_q && sh_cnt_q <= 4'h1;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q     <= '0;
            hold_vld_q <= 1'h0;
        end else begin
            if (hold_load) begin
                hold_q <= hold_src;
            end
            hold_vld_q <= hold_load || (hold_vld_q && !take_w && !in_clear);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_q          <= '0;
            sh_cnt_q      <= 4'h0;
            cfg_data      <= 1'h0;
            cfg_bit_valid <= 1'h0;
        end else if (in_clear) begin
            sh_cnt_q      <= 4'h0;
            cfg_bit_valid <= 1'h0;
        end else if (tick) begin
            cfg_data      <= sh_q[BW-1];
            cfg_bit_valid <= sh_cnt_q != 4'h0;
            if (take_w) begin
                sh_q     <= hold_q;
                sh_cnt_q <= 4'(BW);
            end else if (sh_cnt_q != 4'h0) begin
                sh_q     <= {sh_q[BW-2:0], 1'h0};
                sh_cnt_q <= sh_cnt_q - 4'h1;
            end
        end
    end

    // ****************************************
    // ready and busy pacing
    // ****************************************
    logic [2:0] busy_tk_q;
    logic       busy_done;
    logic       ready_d;

    assign busy_done = busy_tk_q == cbl_pkg::BUSY_MIN_TICKS && !hold_vld_q;
    assign ready_d   = state_q == DV_PERIPH && !wr_end && (link.ready || busy_done);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_tk_q  <= cbl_pkg::BUSY_MIN_TICKS;
            link.ready <= 1'h0;
        end else begin
            if (wr_end) begin
                busy_tk_q <= 3'h0;
            end else if (tick && busy_tk_q != cbl_pkg::BUSY_MIN_TICKS) begin
                busy_tk_q <= busy_tk_q + 3'h1;
            end
            link.ready <= ready_d;
        end
    end

    // ****************************************
    // memory read clock, address and status
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.read_clock <= 1'h0;
            link.mem_addr   <= '0;
            link.init_done  <= 1'h0;
            cfg_active      <= 1'h0;
        end else begin
            link.read_clock <= state_d == DV_MEM_HIGH;
            if (in_clear) begin
                link.mem_addr <= '0;
            end else if (mem_next) begin
                link.mem_addr <= link.mem_addr + cbl_pkg::ADDR_W'(1);
            end
            link.init_done  <= state_d != DV_CLEAR;
            cfg_active      <= state_d == DV_PERIPH || state_d == DV_MEM_LOW ||
                               state_d == DV_MEM_HIGH;
        end
    end
endmodule

// File: pkg/cbl_pkg.sv
// constants shared by both ends of the configuration byte load port
// assumes one 125 MHz system clock on both ends
package cbl_pkg;

    // ****************************************
    // clock and data widths
    // ****************************************
    localparam int CLK_MHZ   = 125;
    localparam int BYTE_W    = 8;
    localparam int ADDR_W    = 16;
    localparam int FIFO_D    = 16;
    localparam int CONFIG_CLOCK_DIV  = 16;
    localparam int CNT_W     = 10;

    // ****************************************
    // write strobe timing
    // ****************************************
    localparam int WRITE_MIN_NS = 100;
    localparam logic [3:0] WRITE_MIN_CYC = 4'((WRITE_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] WRITE_HOLD_CYC = CNT_W'(int'(WRITE_MIN_CYC) + 3);
    localparam int BUSY_DLY_NS = 60;
    localparam int BUSY_DLY_CYC = (BUSY_DLY_NS * CLK_MHZ) / 1000;
    localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(BUSY_DLY_CYC + 2);

    // ****************************************
    // busy length in config clock periods
    // ****************************************
    localparam int BUSY_MIN_TENTHS = 25;
    localparam int BUSY_MAX_PERIODS = 9;
    localparam logic [2:0] BUSY_MIN_TICKS = 3'((BUSY_MIN_TENTHS + 9) / 10 + 1);

    // ****************************************
    // byte-wide memory read clock phases
    // ****************************************
    localparam int READ_LOW_NS  = 4000;
    localparam int READ_HIGH_NS = 600;
    localparam logic [CNT_W-1:0] READ_LOW_CYC  = CNT_W'((READ_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] READ_HIGH_CYC = CNT_W'((READ_HIGH_NS * CLK_MHZ + 999) / 1000);

    // ****************************************
    // reset and program pulse, array clearing
    // ****************************************
    localparam int RESET_PULSE_US = 6;
    localparam logic [CNT_W-1:0] RESET_PULSE_CYC = CNT_W'(RESET_PULSE_US * CLK_MHZ + 1);
    localparam logic [3:0] INIT_CLEAR_CYC = 4'hF;

endpackage

// File: pkg/cbl_if.sv
// pins between the configuration host and the loading port
// assumes both ends run on the same system clock; testbench joins them
`timescale 1ns/10ps
interface cbl_if;
    logic                        chip_select_a_b;
    logic                        chip_select_b_b;
    logic                        chip_select_c_b;
    logic                        write_strobe_b;
    logic [cbl_pkg::BYTE_W-1:0]  wr_data;
    logic                        ready;
    logic                        init_done;
    logic                        cfg_reset_b;
    logic                        done_prog_b;
    logic                        read_clock;
    logic [cbl_pkg::ADDR_W-1:0]  mem_addr;
    logic [cbl_pkg::BYTE_W-1:0]  mem_data;

    modport device (
        input  chip_select_a_b,
        input  chip_select_b_b,
        input  chip_select_c_b,
        input  write_strobe_b,
        input  wr_data,
        input  cfg_reset_b,
        input  done_prog_b,
        input  mem_data,
        output ready,
        output init_done,
        output read_clock,
        output mem_addr
    );

    modport host (
        output chip_select_a_b,
        output chip_select_b_b,
        output chip_select_c_b,
        output write_strobe_b,
        output wr_data,
        output cfg_reset_b,
        output done_prog_b,
        output mem_data,
        input  ready,
        input  init_done,
        input  read_clock,
        input  mem_addr
    );
endinterface

// File: design/cbl_fifo.sv
// byte queue in front of the host end
// assumes one clock; depth is a power of two
`timescale 1ns/10ps
module cbl_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         s_valid,
    input  wire logic [W-1:0] s_data,
    output logic              s_ready,
    output logic              m_valid,
    input  wire logic         m_ready,
    output logic [W-1:0]      m_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   count_q;
    logic [AW:0]   count_d;
    logic          push;
    logic          pop;

    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;
    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign m_data  = mem_q[rd_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= s_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
            s_ready <= 1'h1;
            m_valid <= 1'h0;
        end else begin
            wr_q    <= wr_q + AW'(push);
            rd_q    <= rd_q + AW'(pop);
            count_q <= count_d;
            s_ready <= count_d != (AW+1)'(D);
            m_valid <= count_d != '0;
        end
    end
endmodule

// File: design/cbl_host.sv
// host end: resets the array, then feeds queued bytes as writes or memory data
// assumes device pins arrive from outside the clock domain
`timescale 1ns/10ps
module cbl_host (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    input  wire logic                       memory_mode,
    input  wire logic                       in_valid,
    input  wire logic [cbl_pkg::BYTE_W-1:0] in_data,
    output logic                            in_ready,
    output logic                            link_up,
    cbl_if.host                             link
);
    localparam int BW = cbl_pkg::BYTE_W;
    localparam int CW = cbl_pkg::CNT_W;

    typedef enum logic [6:0] {
        HS_RST_HI    = 7'h01,
        HS_RST_LO    = 7'h02,
        HS_WAIT_INIT = 7'h04,
        HS_IDLE      = 7'h08,
        HS_WRITE     = 7'h10,
        HS_GAP       = 7'h20,
        HS_MEM       = 7'h40
    } cbl_host_state_t;

    // ****************************************
    // queue and pin synchronisers
    // ****************************************
    logic          q_valid;
    logic          q_pop;
    logic [BW-1:0] q_data;

    cbl_fifo #(.W(BW), .D(cbl_pkg::FIFO_D)) i_cbl_fifo (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .s_valid (in_valid),
        .s_data  (in_data),
        .s_ready (in_ready),
        .m_valid (q_valid),
        .m_ready (q_pop),
        .m_data  (q_data)
    );

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       rc_prev_q;
    logic       init_s;
    logic       ready_s;
    logic       rc_rise;

    assign init_s  = sync_q[2];
    assign ready_s = sync_q[1];
    assign rc_rise = sync_q[0] && !rc_prev_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q    <= 3'h0;
            sync_q    <= 3'h0;
            rc_prev_q <= 1'h0;
        end else begin
            meta_q    <= {link.init_done, link.ready, link.read_clock};
            sync_q    <= meta_q;
            rc_prev_q <= sync_q[0];
        end
    end

    // ****************************************
    // state machine
    // ****************************************
    cbl_host_state_t state_q;
    cbl_host_state_t state_d;
    logic [CW-1:0]   cnt_q;
    logic            mem_vld_q;
    logic            wr_go;

    assign wr_go = state_q == HS_IDLE && q_valid && ready_s;
    assign q_pop = wr_go || (state_q == HS_MEM && !mem_vld_q && q_valid);

    always_comb begin
        state_d = state_q;
        case (state_q)
            HS_RST_HI: begin
                if (cnt_q == cbl_pkg::RESET_PULSE_CYC) begin
                    state_d = HS_RST_LO;
                end
            end
            HS_RST_LO: begin
                if (cnt_q == cbl_pkg::RESET_PULSE_CYC) begin
                    state_d = HS_WAIT_INIT;
                end
            end
            HS_WAIT_INIT: begin
                if (init_s) begin
                    state_d = memory_mode ? HS_MEM : HS_IDLE;
                end
            end
            HS_IDLE: begin
                if (wr_go) begin
                    state_d = HS_WRITE;
                end
            end
            HS_WRITE: begin
                if (cnt_q == cbl_pkg::WRITE_HOLD_CYC) begin
                    state_d = HS_GAP;
                end
            end
            HS_GAP: begin
                if (cnt_q == cbl_pkg::GAP_CYC) begin
                    state_d = HS_IDLE;
                end
            end
            HS_MEM: begin
                state_d = HS_MEM;
            end
            default: begin
                state_d = HS_RST_HI;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= HS_RST_HI;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_d != state_q) ? '0 : cnt_q + CW'(1);
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    logic sel_b_d;

    assign sel_b_d = state_d != HS_WRITE;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.cfg_reset_b     <= 1'h1;
            link.done_prog_b     <= 1'h1;
            link.chip_select_a_b <= 1'h1;
            link.chip_select_b_b <= 1'h1;
            link.chip_select_c_b <= 1'h1;
            link.write_strobe_b  <= 1'h1;
            link.wr_data         <= '0;
            link.mem_data        <= '0;
            mem_vld_q            <= 1'h0;
            link_up              <= 1'h0;
        end else begin
            link.cfg_reset_b     <= state_d != HS_RST_LO && state_d != HS_WAIT_INIT;
            link.done_prog_b     <= state_d != HS_RST_LO;
            link.chip_select_a_b <= sel_b_d;
            link.chip_select_b_b <= sel_b_d;
            link.chip_select_c_b <= sel_b_d;
            link.write_strobe_b  <= sel_b_d;
            if (wr_go) begin
                link.wr_data <= q_data;
            end
            if (state_q == HS_MEM && !mem_vld_q && q_valid) begin
                link.mem_data <= q_data;
                mem_vld_q     <= 1'h1;
            end else if (rc_rise) begin
                mem_vld_q <= 1'h0;
            end
            link_up              <= state_d == HS_IDLE || state_d == HS_WRITE ||
                                    state_d == HS_GAP || state_d == HS_MEM;
        end
    end
endmodule

// File: test/cbl_sva.sv
// pin checker for the config byte load port
// assumes one clock, default config clock divide of 16
`timescale 1ns/10ps
module cbl_sva (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        chip_select_a_b,
    input wire logic        chip_select_b_b,
    input wire logic        chip_select_c_b,
    input wire logic        write_strobe_b,
    input wire logic [7:0]  wr_data,
    input wire logic        ready,
    input wire logic        init_done,
    input wire logic        cfg_reset_b,
    input wire logic        done_prog_b,
    input wire logic        read_clock,
    input wire logic [15:0] mem_addr
);
    logic        joint_low;
    logic [11:0] low_cnt_q;
    assign joint_low = !(chip_select_a_b | chip_select_b_b | chip_select_c_b | write_strobe_b);
    // length of the read clock low phase
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) low_cnt_q <= 12'h000;
        else if (read_clock) low_cnt_q <= 12'h000;
        else if (low_cnt_q != 12'hFFF) low_cnt_q <= low_cnt_q + 12'h001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // both pins high: a busy drop then comes from a write, not an abort
    logic pins_up;
    assign pins_up = cfg_reset_b && done_prog_b;
    write_long_a: assert property (
        $fell(write_strobe_b) |-> joint_low throughout ##12 1'h1)
        else $error("write strobe too short");
    data_held_a: assert property (
        !write_strobe_b && !$past(write_strobe_b) |-> $stable(wr_data))
        else $error("write data moved during strobe");
    busy_soon_a: assert property ($rose(write_strobe_b) && init_done |-> ##[1:7] !ready)
        else $error("busy late after write");
    busy_span_a: assert property (
        $fell(ready) && pins_up |-> (!ready throughout ##36 1'h1) ##[1:105] ready)
        else $error("busy length out of range");
    write_ready_a: assert property ($fell(write_strobe_b) |-> ready)
        else $error("write started while busy");
    reset_hold_a: assert property (!cfg_reset_b [*5] |-> !ready && !read_clock)
        else $error("loading while reset low");
    init_clear_a: assert property (!done_prog_b |-> ##[1:4] !init_done)
        else $error("init not cleared by program");
    read_low_a: assert property ($rose(read_clock) |-> low_cnt_q >= 12'h1F4)
        else $error("read clock low phase short");
    read_high_a: assert property (
        $rose(read_clock) |-> (read_clock throughout ##75 1'h1) ##1 !read_clock)
        else $error("read clock high phase wrong");
    addr_next_a: assert property (
        $fell(read_clock) |-> mem_addr == 16'($past(mem_addr) + 16'h0001))
        else $error("memory address not advanced");
    cover property ($rose(ready));
    cover property ($fell(read_clock));
    cover property ($rose(joint_low));
endmodule

// File: test/test_config_byte_load_port.sv
// self-checking bench: host and device ends joined by one interface
// assumes default parameters; bytes go queue, pins, serial output
`timescale 1ns/10ps
module test_config_byte_load_port;
    logic       sys_clk;
    logic       rst_b;
    logic       memory_mode;
    logic       in_valid;
    logic [7:0] in_data;
    logic       in_ready;
    logic       link_up;
    logic       config_clock;
    logic       cfg_data;
    logic       cfg_bit_valid;
    logic       cfg_active;
    logic [7:0] shift_q;
    logic [7:0] rx_q[$];
    int         nbits;
    int         num_errors;
    int         n_compared;

    cbl_if link_if();
    cbl_host i_cbl_host (.sys_clk(sys_clk), .rst_b(rst_b), .memory_mode(memory_mode),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .link_up(link_up),
        .link(link_if));
    cbl_device i_cbl_device (.sys_clk(sys_clk), .rst_b(rst_b), .memory_mode(memory_mode),
        .link(link_if), .config_clock(config_clock), .cfg_data(cfg_data),
        .cfg_bit_valid(cfg_bit_valid), .cfg_active(cfg_active));
    cbl_sva chk (.sys_clk(sys_clk), .rst_b(rst_b), .chip_select_a_b(link_if.chip_select_a_b),
        .chip_select_b_b(link_if.chip_select_b_b), .chip_select_c_b(link_if.chip_select_c_b),
        .write_strobe_b(link_if.write_strobe_b), .wr_data(link_if.wr_data),
        .ready(link_if.ready), .init_done(link_if.init_done), .cfg_reset_b(link_if.cfg_reset_b),
        .done_prog_b(link_if.done_prog_b), .read_clock(link_if.read_clock),
        .mem_addr(link_if.mem_addr));

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    // serial bytes, sampled on config clock rise
    // bits shifted before the host's reset pulse are not part of the load
    always @(posedge config_clock) begin
        if (cfg_bit_valid === 1'h1 && link_up === 1'h1) begin
            shift_q = {shift_q[6:0], cfg_data};
            nbits++;
            if (nbits % 8 == 0) rx_q.push_back(shift_q);
        end
    end

    function automatic logic [7:0] pattern(input int k);
        return 8'(k * 8'h3B + 8'hA5);
    endfunction

    task automatic fail(input string msg);
        num_errors++;
        $display("FAIL %0t %s", $time, msg);
    endtask

    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // reset both ends, queue n bytes, expect them serialised in order
    task automatic run(input logic mode, input int n);
        int k;
        rst_b = 1'h0;
        memory_mode = mode;
        repeat (16) @(negedge sys_clk);
        rst_b = 1'h1;
        nbits = 0;
        rx_q.delete();
        n_compared++;
        if (link_up !== 1'h0 || link_if.init_done !== 1'h0) fail("link up too early");
        for (k = 0; k < n; k++) begin
            in_valid = 1'h1;
            in_data = pattern(k);
            while (in_ready !== 1'h1) @(negedge sys_clk);
            @(negedge sys_clk);
        end
        in_valid = 1'h0;
        n_compared++;
        if (in_ready !== (n < 16)) fail("queue fill level wrong");
        for (k = 0; k < 40000 && rx_q.size() < n; k++) @(negedge sys_clk);
        n_compared++;
        if (link_up !== 1'h1 || cfg_active !== 1'h1) fail("link not active");
        for (k = 0; k < n; k++) begin
            n_compared++;
            if (rx_q.size() <= k || rx_q[k] !== pattern(k)) fail("serial byte wrong");
        end
        n_compared++;
        if (in_ready !== 1'h1) fail("queue not drained");
    endtask

    initial begin
        repeat (30000) @(posedge sys_clk);
        fail("watchdog expired");
        complete_run();
    end

    initial begin
        rst_b = 1'h0;
        memory_mode = 1'h0;
        in_valid = 1'h0;
        in_data = 8'h00;
        shift_q = 8'h00;
        nbits = 0;
        num_errors = 0;
        n_compared = 0;
        run(1'h0, 16);
        run(1'h1, 4);
        complete_run();
    end
endmodule
